/* common/tsf_defines.svh */
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// Lane word layout.
`define TSF_LANE_BITS 32
`define TSF_BYTES_PER_WORD 4
`define TSF_BYTE_BITS 8

// Byte position masks of a frame or multiframe start inside a lane word.
`define TSF_POS_BYTE0 4'h1
`define TSF_POS_BYTE1 4'h2
`define TSF_POS_BYTE2 4'h4
`define TSF_POS_BYTE3 4'h8
`define TSF_POS_ALL 4'hF
`define TSF_POS_NONE 4'h0

// Reset values.
`define TSF_RST_POS 4'h0
`define TSF_RST_SYNC 3'h0

// Input synchroniser depth and last byte index of a word.
`define TSF_SYNC_STAGES 3
`define TSF_LAST_BYTE 2'h3

// Default frame geometry: octets per frame and frames per multiframe.
`define TSF_DEF_OCTETS 8
`define TSF_DEF_FRAMES 4

`endif

/* common/tsf_pkg.sv */
package tsf_pkg;

    // Stream life cycle of the transmit data interface.
    typedef enum logic [1:0] {
        TSF_ST_RESET,
        TSF_ST_WAIT_SYNC,
        TSF_ST_DATA
    } tsf_state_t;

    typedef logic [3:0] tsf_pos_t;
    typedef logic [15:0] tsf_count_t;

endpackage : tsf_pkg

/* common/tsf_stream_if.sv */
`timescale 1ns/10ps
interface tsf_stream_if #(
    parameter int WIDTH = 32
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : tsf_stream_if

/* design/tsf_skid_buffer.sv */
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tsf_skid_buffer #(
    parameter int WIDTH = 32
) (
    input wire logic i_clk_sys,   // core clock
    input wire logic i_resetn,    // async reset, active low
    input wire logic i_flush,     // drop contents and refuse input
    tsf_stream_if.snk up,         // filling side
    tsf_stream_if.src dn          // draining side
);
    import tsf_pkg::*;

    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic [1:0] count;
    logic [1:0] next_count;
    logic rd_ptr;
    logic next_rd_ptr;
    logic wr_ptr;
    logic next_wr_ptr;
    logic in_ready;
    logic next_in_ready;
    logic push;
    logic pop;

    assign up.ready = in_ready;
    assign dn.valid = (count != 2'h0);
    assign dn.data = mem[rd_ptr];

    always_comb begin
        push = up.valid && in_ready;
        pop = dn.valid && dn.ready;
        next_mem = mem;
        next_count = count;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        if (i_flush) begin
            next_count = 2'h0;
            next_rd_ptr = 1'b0;
            next_wr_ptr = 1'b0;
        end else begin
            if (push) begin
                next_mem[wr_ptr] = up.data;
                next_wr_ptr = ~wr_ptr;
            end
            if (pop) begin
                next_rd_ptr = ~rd_ptr;
            end
            next_count = count + {1'b0, push} - {1'b0, pop};
        end
        // Registered ready: the source sees a stall one word early, so two entries suffice.
        next_in_ready = !i_flush && (next_count == 2'h0);
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mem[0] <= '0;
            mem[1] <= '0;
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            mem <= next_mem;
            count <= next_count;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            in_ready <= next_in_ready;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_buf_no_overflow: assert property (count <= 2'h2)
        else $error("Buffer holds more than two words.");
    a_buf_full_stall: assert property ((count != 2'h0) |-> !in_ready)
        else $error("Buffer ready while holding a word.");
endmodule : tsf_skid_buffer

/* design/tsf_lane_serializer.sv */
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tsf_lane_serializer #(
    parameter int LANES = 1
) (
    input wire logic i_clk_sys,                      // core clock
    input wire logic i_resetn,                       // async reset, active low
    input wire logic i_flush,                        // abandon the word in progress
    input wire logic i_line_ready,                   // line side takes an octet
    tsf_stream_if.snk wd,                            // lane words in
    output logic [`TSF_BYTE_BITS*LANES-1:0] o_octet, // one octet per lane
    output logic o_octet_valid                       // octets valid
);
    import tsf_pkg::*;

    localparam int WB = `TSF_LANE_BITS * LANES;

    logic [WB-1:0] word;
    logic [WB-1:0] next_word;
    logic busy;
    logic next_busy;
    logic [1:0] idx;
    logic [1:0] next_idx;
    logic [`TSF_BYTE_BITS*LANES-1:0] next_octet;
    logic next_octet_valid;
    logic slot_free;

    assign wd.ready = !busy && !i_flush;

    always_comb begin
        next_word = word;
        next_busy = busy;
        next_idx = idx;
        next_octet = o_octet;
        next_octet_valid = o_octet_valid;
        slot_free = !o_octet_valid || i_line_ready;
        if (i_flush) begin
            next_busy = 1'b0;
            next_idx = 2'h0;
            next_octet_valid = 1'b0;
        end else begin
            if (slot_free) begin
                next_octet_valid = busy;
            end
            if (busy && slot_free) begin
                // Least significant byte of each lane leaves first. [RULE_02]
                for (int l = 0; l < LANES; l++) begin
                    next_octet[l*`TSF_BYTE_BITS +: `TSF_BYTE_BITS] =
                        word[l*`TSF_LANE_BITS + idx*`TSF_BYTE_BITS +: `TSF_BYTE_BITS];
                end
                next_idx = idx + 2'h1;
                next_busy = (idx != `TSF_LAST_BYTE);
            end
            if (wd.valid && !busy) begin
                next_word = wd.data;
                next_busy = 1'b1;
                next_idx = 2'h0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            word <= '0;
            busy <= 1'b0;
            idx <= 2'h0;
            o_octet <= '0;
            o_octet_valid <= 1'b0;
        end else begin
            word <= next_word;
            busy <= next_busy;
            idx <= next_idx;
            o_octet <= next_octet;
            o_octet_valid <= next_octet_valid;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_ser_lsb_first: assert property ((wd.valid && wd.ready && !i_flush ##1 i_line_ready && !i_flush)
        |=> (o_octet[`TSF_BYTE_BITS-1:0] == $past(wd.data[`TSF_BYTE_BITS-1:0], 2))) // [RULE_02]
        else $error("First octet out is not the low byte of lane 0.");
    a_ser_hold_stall: assert property ((o_octet_valid && !i_line_ready && !i_flush)
        |=> (o_octet_valid && $stable(o_octet)))
        else $error("Octet changed while the line stalled.");
endmodule : tsf_lane_serializer

/* design/tsf_tx_frame_if.sv */
`timescale 1ns/10ps
`include "tsf_defines.svh"

// What this block does
// [RULE_01] Each lane owns 32 bits, lane n at 32n.
// [RULE_02] Lane word leaves low byte first.
// [RULE_03] Frame start mask describes next accepted word.
// [RULE_04] Value 0001: frame starts in byte 0.
// [RULE_05] Value 0010: frame starts in byte 1.
// [RULE_06] Value 0100: frame starts in byte 2.
// [RULE_07] Value 1000: frame starts in byte 3.
// [RULE_08] Short frames set several bits, F=1 gives 1111.
// [RULE_09] Ready output marks words taken in.
// [RULE_10] One active-low stream reset for all lanes.
// [RULE_11] Everything on the transmit core clock.
// [RULE_12] Multiframe start mask, same code and timing.
// [RULE_13] Far end holds sync low until aligned.
// [RULE_14] Source presents valid data whenever ready.
module tsf_tx_frame_if #(
    parameter int LANES = 1,                   // serial lanes
    parameter int OCTETS = `TSF_DEF_OCTETS,    // octets per frame, F
    parameter int FRAMES = `TSF_DEF_FRAMES     // frames per multiframe, K
) (
    input wire logic i_clk_sys,                                       // core clock
    input wire logic i_resetn,                                        // async reset, active low
    input wire logic [`TSF_LANE_BITS*LANES-1:0] i_tdata,              // sample words
    input wire logic i_sync_n,                                        // far-end sync request
    input wire logic i_line_ready,                                    // line takes octets
    output logic o_tready,                                            // word taken this cycle
    output logic o_stream_resetn,                                     // stream reset, active low
    output tsf_pkg::tsf_pos_t o_tx_frame_first_byte_pos,              // frame start mask
    output tsf_pkg::tsf_pos_t o_tx_mframe_first_byte_pos,             // multiframe start mask
    output logic [`TSF_BYTE_BITS*LANES-1:0] o_lane_octet,             // octet per lane
    output logic o_lane_octet_valid                                   // octets valid
);
    import tsf_pkg::*;

    localparam int WB = `TSF_LANE_BITS * LANES;
    localparam int MF_OCTETS = OCTETS * FRAMES;

    ////////////////////////////////////////////////////////////////////////////////
    // Sync request input: three stages, a change counts once the last two agree.

    logic [`TSF_SYNC_STAGES-1:0] sync_sr;
    logic [`TSF_SYNC_STAGES-1:0] next_sync_sr;
    logic sync_level;
    logic next_sync_level;

    always_comb begin
        next_sync_sr = {sync_sr[`TSF_SYNC_STAGES-2:0], i_sync_n};
        next_sync_level = sync_level;
        if (sync_sr[1] == sync_sr[2]) begin
            next_sync_level = sync_sr[2];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_sr <= `TSF_RST_SYNC;
            sync_level <= 1'b0;
        end else begin
            sync_sr <= next_sync_sr;
            sync_level <= next_sync_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stream life cycle and the stream reset.

    tsf_state_t state;
    tsf_state_t next_state;
    logic next_stream_resetn;
    logic active;

    always_comb begin
        next_state = state;
        unique case (state)
            TSF_ST_RESET: begin
                next_state = TSF_ST_WAIT_SYNC;
            end
            TSF_ST_WAIT_SYNC: begin
                // The far end keeps sync low until its aligner is done. [RULE_13]
                if (sync_level) begin
                    next_state = TSF_ST_DATA;
                end
            end
            TSF_ST_DATA: begin
                if (!sync_level) begin
                    next_state = TSF_ST_WAIT_SYNC;
                end
            end
        endcase
        // Held low outside data so every lane restarts its frame count together. [RULE_10]
        next_stream_resetn = (next_state == TSF_ST_DATA);
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= TSF_ST_RESET;
            o_stream_resetn <= 1'b0;
        end else begin
            state <= next_state;
            o_stream_resetn <= next_stream_resetn;
        end
    end

    assign active = o_stream_resetn;

    ////////////////////////////////////////////////////////////////////////////////
    // Data path: two-entry buffer, then the lane serialiser.

    tsf_stream_if #(.WIDTH(WB)) in_if ();
    tsf_stream_if #(.WIDTH(WB)) mid_if ();

    // No valid comes with the samples: the source has a word whenever ready is high. [RULE_14]
    assign in_if.valid = active;
    assign in_if.data = i_tdata; // [RULE_01]

    // The buffer flushes on the edge that resets the stream, so ready never outlives it.
    tsf_skid_buffer #(.WIDTH(WB)) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_flush(!active || !next_stream_resetn),
        .up(in_if),
        .dn(mid_if)
    );

    // Ready is the buffer's own registered ready, so it is a flip-flop. [RULE_09]
    assign o_tready = in_if.ready;

    tsf_lane_serializer #(.LANES(LANES)) u_ser (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_flush(!active),
        .i_line_ready(i_line_ready),
        .wd(mid_if),
        .o_octet(o_lane_octet),
        .o_octet_valid(o_lane_octet_valid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Frame and multiframe start positions of the next word to be accepted.

    tsf_count_t fpos;
    tsf_count_t next_fpos;
    tsf_count_t mpos;
    tsf_count_t next_mpos;
    tsf_pos_t next_frame_pos;
    tsf_pos_t next_mframe_pos;
    logic accept;

    // Octet counter step with wrap; avoids a divider for arbitrary frame sizes.
    function automatic tsf_count_t step(input tsf_count_t p, input int size);
        tsf_count_t lim;
        lim = tsf_count_t'(size - 1);
        step = (p == lim) ? '0 : p + 16'h0001;
    endfunction : step

    // Bit b is set when byte b of the lane word is octet 0 of its frame. [RULE_08]
    function automatic tsf_pos_t pos_mask(input tsf_count_t p, input int size);
        tsf_count_t q;
        pos_mask = `TSF_POS_NONE;
        q = p;
        for (int b = 0; b < `TSF_BYTES_PER_WORD; b++) begin
            pos_mask[b] = (q == '0);
            q = step(q, size);
        end
    endfunction : pos_mask

    always_comb begin
        accept = o_tready && active;
        next_fpos = fpos;
        next_mpos = mpos;
        if (!next_stream_resetn) begin
            next_fpos = '0;
            next_mpos = '0;
        end else if (accept) begin
            for (int b = 0; b < `TSF_BYTES_PER_WORD; b++) begin
                next_fpos = step(next_fpos, OCTETS);
                next_mpos = step(next_mpos, MF_OCTETS);
            end
        end
        // Codes 0001, 0010, 0100, 1000 fall out of the mask. [RULE_04] [RULE_05]
        next_frame_pos = pos_mask(next_fpos, OCTETS); // [RULE_06] [RULE_07]
        next_mframe_pos = pos_mask(next_mpos, MF_OCTETS); // [RULE_12]
    end

    // Shown one cycle before the word they describe is taken. [RULE_03] [RULE_11]
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            fpos <= '0;
            mpos <= '0;
            o_tx_frame_first_byte_pos <= `TSF_RST_POS;
            o_tx_mframe_first_byte_pos <= `TSF_RST_POS;
        end else begin
            fpos <= next_fpos;
            mpos <= next_mpos;
            o_tx_frame_first_byte_pos <= next_frame_pos;
            o_tx_mframe_first_byte_pos <= next_mframe_pos;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_sync_rise;
        !sync_level ##1 sync_level;
    endsequence

    sequence s_first_accept;
        o_stream_resetn && o_tready;
    endsequence

    a_stream_start_mask: assert property (s_sync_rise ##1 o_stream_resetn
        |-> o_tx_frame_first_byte_pos[0] && o_tx_mframe_first_byte_pos[0]) // [RULE_04]
        else $error("First word after stream start does not open a frame in byte 0.");
    a_reset_follows_sync: assert property ((state == TSF_ST_WAIT_SYNC) && sync_level
        |=> o_stream_resetn) // [RULE_10]
        else $error("Stream reset not released one cycle after sync.");
    a_reset_on_sync_drop: assert property ((state == TSF_ST_DATA) && !sync_level
        |=> !o_stream_resetn && !o_tready ##1 !o_tready) // [RULE_10]
        else $error("Stream not held in reset after sync loss.");
    a_ready_needs_stream: assert property (o_tready |-> o_stream_resetn) // [RULE_09]
        else $error("Ready raised while the stream is in reset.");
    a_mask_steady_idle: assert property (o_stream_resetn && !o_tready && next_stream_resetn
        && $past(o_stream_resetn)
        |=> $stable(o_tx_frame_first_byte_pos) && $stable(o_tx_mframe_first_byte_pos)) // [RULE_03]
        else $error("Start masks moved without an accepted word.");
    a_mframe_in_frame: assert property (o_stream_resetn
        |-> ((o_tx_mframe_first_byte_pos & ~o_tx_frame_first_byte_pos) == `TSF_POS_NONE)) // [RULE_12]
        else $error("Multiframe start outside a frame start.");
    a_single_octet_all: assert property ((OCTETS == 1) && o_stream_resetn
        |-> (o_tx_frame_first_byte_pos == `TSF_POS_ALL)) // [RULE_08]
        else $error("One-octet frames must mark all four bytes.");
    a_mask_advances: assert property (s_first_accept
        |=> ((`TSF_BYTES_PER_WORD % OCTETS) != 0)
            || $stable(o_tx_frame_first_byte_pos)) // [RULE_07]
        else $error("Frame mask moved for a frame length that divides a word.");
    a_sync_settles: assert property ($rose(sync_level) |-> ##1 (state == TSF_ST_DATA)) // [RULE_11]
        else $error("Data state not entered one cycle after sync.");

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on ready, the synchroniser and the one-hot start codes.

    sequence s_take;
        o_stream_resetn && o_tready;
    endsequence

    sequence s_sync_fall;
        sync_level ##1 !sync_level;
    endsequence

    // A taken word sits in the buffer for at least one cycle, so ready must fall.
    a_ready_after_take: assert property (s_take |=> !o_tready) // [RULE_09]
        else $error("Ready stayed high while the buffer holds the taken word.");
    a_ready_on_start: assert property ($rose(o_stream_resetn) && sync_level
        |-> !o_tready ##1 o_tready) // [RULE_09]
        else $error("Ready did not rise one cycle after the stream started.");
    a_stream_drop: assert property (s_sync_fall |=> !o_stream_resetn) // [RULE_10]
        else $error("Stream reset not asserted after the sync request fell.");
    a_flush_empties: assert property (!o_stream_resetn ##1 !o_stream_resetn
        |-> !o_lane_octet_valid) // [RULE_10]
        else $error("Octets still offered while the stream is held in reset.");
    a_sync_filtered: assert property ((sync_sr[1] != sync_sr[2])
        |=> $stable(sync_level)) // [RULE_11]
        else $error("Sync level moved while its last two stages disagree.");
    a_data_needs_sync: assert property ((state == TSF_ST_DATA)
        |-> $past(sync_level)) // [RULE_13]
        else $error("Data state entered without a sync request.");
    // Frames of four octets or more can start at most once per lane word.
    a_frame_one_start: assert property ((OCTETS >= `TSF_BYTES_PER_WORD) && o_stream_resetn
        |-> $onehot0(o_tx_frame_first_byte_pos)) // [RULE_04]
        else $error("Several frame starts in one word for a long frame.");
    a_mframe_one_start: assert property ((MF_OCTETS >= `TSF_BYTES_PER_WORD) && o_stream_resetn
        |-> $onehot0(o_tx_mframe_first_byte_pos)) // [RULE_12]
        else $error("Several multiframe starts in one word.");
    a_held_masks_home: assert property (!next_stream_resetn
        |=> o_tx_frame_first_byte_pos[0] && o_tx_mframe_first_byte_pos[0]) // [RULE_03]
        else $error("Held stream does not point the next word at byte 0.");
    a_running_in_data: assert property (o_stream_resetn |-> (state == TSF_ST_DATA)) // [RULE_10]
        else $error("Stream released outside the data state.");
endmodule : tsf_tx_frame_if

/* testbench/tsf_src_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tsf_src_model #(
    parameter int LANES = 2
) (
    input wire logic i_clk_sys,         // core clock
    input wire logic i_resetn,          // reset, active low
    output logic [32*LANES-1:0] o_tdata // sample words, lane n at 32n
);
    int seed = 63831;

    // A fresh word every cycle: with no valid qualifier, whatever stands here
    // on a ready edge is taken, and a held word would hide a take on the wrong edge.
    initial o_tdata = '0;
    always @(posedge i_clk_sys) begin
        for (int n = 0; n < LANES; n++) begin
            o_tdata[32*n +: 32] <= i_resetn ? $random(seed) : 32'h0;
        end
    end
endmodule : tsf_src_model

/* testbench/tsf_tb_lane_pair.sv */
`timescale 1ns/10ps
`include "tsf_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module tsf_tb_lane_pair #(
    parameter int OCTETS = 5,
    parameter int FRAMES = 4
) (
    input wire logic i_clk_sys, // core clock
    input wire logic i_resetn,  // reset, active low
    input wire logic i_sync_n   // far-end sync request
);
    import tsf_pkg::*;
    localparam int LANES = 2;
    localparam int MF = OCTETS * FRAMES;
    logic [32*LANES-1:0] tdata;
    logic line_ready = 1'b0;
    logic tready;
    logic srst_n;
    logic oct_valid;
    tsf_pos_t frm;
    tsf_pos_t mfrm;
    logic [8*LANES-1:0] octet;
    logic [8*LANES-1:0] q[$];
    int pos = 0;
    int err = 0;
    int cnt = 0;
    int n_oct = 0;
    int cyc = 0;
    int seed = 63831;

    tsf_src_model #(.LANES(LANES)) tsf_src_model_i (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .o_tdata(tdata)
    );

    tsf_tx_frame_if #(.LANES(LANES), .OCTETS(OCTETS), .FRAMES(FRAMES)) tsf_tx_frame_if_i (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_tdata(tdata),
        .i_sync_n(i_sync_n),
        .i_line_ready(line_ready),
        .o_tready(tready),
        .o_stream_resetn(srst_n),
        .o_tx_frame_first_byte_pos(frm),
        .o_tx_mframe_first_byte_pos(mfrm),
        .o_lane_octet(octet),
        .o_lane_octet_valid(oct_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic tsf_pos_t exp_mask(input int p, input int m);
        tsf_pos_t r;
        for (int b = 0; b < 4; b++) begin
            r[b] = ((p + b) % m == 0);
        end
        return r;
    endfunction : exp_mask

    task automatic cmp_pos(input string what, input tsf_pos_t exp, input tsf_pos_t got);
        cnt++;
        if (got !== exp) begin
            err++;
            $display("MISMATCH %s F=%0d expected %b seen %b", what, OCTETS, exp, got);
        end
    endtask : cmp_pos

    task automatic cmp_oct(input string what, input logic [15:0] exp, input logic [15:0] got);
        cnt++;
        if (got !== exp) begin
            err++;
            $display("MISMATCH %s F=%0d expected %h seen %h", what, OCTETS, exp, got);
        end
    endtask : cmp_oct

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cnt++;
        if (got !== exp) begin
            err++;
            $display("MISMATCH %s F=%0d expected %b seen %b", what, OCTETS, exp, got);
        end
    endtask : cmp_bit

    ////////////////////////////////////////////////////////////////////////////
    // Long stalls every 400 cycles leave a word in the buffer so that ready must refuse.
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        line_ready <= (cyc % 400 >= 40) && (($random(seed) & 3) != 0);
        if (cyc > 400 && cyc % 400 == 39 && srst_n === 1'b1) begin
            cmp_bit("ready after long stall", 1'b0, tready);
        end
    end

    // Notes each taken word and checks the masks shown for it.
    always @(posedge i_clk_sys) begin
        if (srst_n !== 1'b1) begin
            cmp_bit("ready while stream held", 1'b0, tready);
            q.delete();
            pos = 0;
        end else if (tready === 1'b1) begin
            cmp_pos("frame mask", exp_mask(pos, OCTETS), frm);
            cmp_pos("mframe mask", exp_mask(pos, MF), mfrm);
            for (int b = 0; b < 4; b++) begin
                q.push_back({tdata[32+8*b +: 8], tdata[8*b +: 8]});
            end
            pos = (pos + 4) % MF;
        end
    end

    // Watches the line side and takes the oldest note whenever octets leave.
    always @(posedge i_clk_sys) begin
        if (srst_n === 1'b1 && oct_valid === 1'b1 && line_ready === 1'b1) begin
            n_oct++;
            if (q.size() == 0) begin
                cnt++;
                err++;
                $display("MISMATCH spare octet F=%0d expected none seen %h", OCTETS, octet);
            end else begin
                cmp_oct("lane octets", q.pop_front(), octet);
            end
        end
    end
endmodule : tsf_tb_lane_pair

/* testbench/tb_tsf_tx_frame_if.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb_tsf_tx_frame_if;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b1;
    logic i_sync_n = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;

    always #25 i_clk_sys = ~i_clk_sys;

    // F=5 walks the start through bytes 0..3 and an empty word; F=1 sets all four.
    tsf_tb_lane_pair #(.OCTETS(5), .FRAMES(4)) h_f5 (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_sync_n(i_sync_n)
    );
    tsf_tb_lane_pair #(.OCTETS(1), .FRAMES(4)) h_f1 (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_sync_n(i_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_flag(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_flag

    task automatic tally_and_finish();
        error_cnt = error_cnt + h_f5.err + h_f1.err;
        n_tests = n_tests + h_f5.cnt + h_f1.cnt;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////
    // A falling edge at time zero resets the flops before the first clock edge.
    initial begin
        i_resetn <= 1'b0;
        repeat (12) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp_flag("stream held before sync f5", 1'b0, h_f5.srst_n);
        cmp_flag("stream held before sync f1", 1'b0, h_f1.srst_n);
        @(posedge i_clk_sys);
        i_sync_n <= 1'b1;
        repeat (1500) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp_flag("stream running f5", 1'b1, h_f5.srst_n);
        cmp_flag("stream running f1", 1'b1, h_f1.srst_n);
        @(posedge i_clk_sys);
        i_sync_n <= 1'b0;
        repeat (30) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp_flag("stream reset on sync loss f5", 1'b0, h_f5.srst_n);
        cmp_flag("stream reset on sync loss f1", 1'b0, h_f1.srst_n);
        @(posedge i_clk_sys);
        i_sync_n <= 1'b1;
        repeat (1500) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp_flag("octets flowing f5", 1'b1, h_f5.n_oct > 500);
        cmp_flag("octets flowing f1", 1'b1, h_f1.n_oct > 500);
        tally_and_finish();
    end

    // The sequence needs about 3100 cycles; 5000 leaves room without hiding a hang.
    initial begin
        #(50 * 5000);
        error_cnt = error_cnt + 1;
        tally_and_finish();
    end
endmodule : tb_tsf_tx_frame_if
